// *** core/clock_unit_select.sv ***
// Purpose: Interrupt enables, system clock select and PLL modulation control
// Assumes: Status inputs synchronous to clk; protect bit from protection register
// Notes: One wait state on every APB access
`timescale 1ns/1ps

module clock_unit_select
    import clock_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic writeProtect,
    input wire logic specialMode,
    input wire logic watchdogConfigTaken,
    input wire logic fullStopEntry,
    input wire logic stopActive,
    input wire logic periodicTimerEvent,
    input wire logic pllLockIn,
    input wire logic oscQualifiedIn,
    output logic periodicIrq,
    output logic lockIrq,
    output logic oscIrq,
    output logic systemClockFromPll,
    output logic keepOscillatorInStop,
    output logic timerClockSelect,
    output logic watchdogClockSelect,
    output logic timerHalted,
    output logic watchdogHalted,
    output logic timerRestart,
    output logic watchdogRestart,
    output logic pllDivideByFour,
    output logic pllStatusClear,
    output logic [1:0] freqModAmplitude
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rstSync1;
    logic rstnSync;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync1 <= 1'b0;
            rstnSync <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstnSync <= rstSync1;
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
        byteAddr = {idx, 2'b00};
    endfunction : byteAddr

    logic [7:0] flagsReg;
    logic [7:0] irqEnable;
    logic [7:0] clockSelect;
    logic [7:0] pllModulation;
    logic lockStatus;
    logic oscQualified;
    logic watchdogOnceUsed;
    logic watchdogRearm;

    wire accessDone = psel && penable && pready;
    wire wrDone = accessDone && pwrite;
    wire hitFlags = paddr == byteAddr(IDX_FLAGS);
    wire hitIrqEn = paddr == byteAddr(IDX_IRQ_EN);
    wire hitClkSel = paddr == byteAddr(IDX_CLK_SEL);
    wire hitPllMod = paddr == byteAddr(IDX_PLL_MOD);
    wire hitAny = hitFlags || hitIrqEn || hitClkSel || hitPllMod;
    wire [7:0] wrByte = pwdata[7:0];

    wire flagsWrite = wrDone && hitFlags;
    wire irqEnWrite = wrDone && hitIrqEn;
    wire clkSelWrite = wrDone && hitClkSel && !writeProtect;
    wire pllWriteTry = wrDone && hitPllMod;
    wire pllWrite = pllWriteTry && !writeProtect && clockSelect[BIT_PLL_SEL];

    wire [7:0] statusByte = {flagsReg[7:4], lockStatus, flagsReg[2:1], oscQualified};
    wire [7:0] readByte = hitFlags ? statusByte :
                          hitIrqEn ? irqEnable :
                          hitClkSel ? clockSelect :
                          hitPllMod ? pllModulation : 8'h00;

    // Ready one cycle into the access phase; error only for unmapped addresses
    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hitAny;
            prdata <= {24'h00_0000, readByte};
        end
    end

    // ************************************************************
    // Status and change flags
    // ************************************************************
    // A PLL rewrite drops both status bits for one cycle; after that they follow pllLockIn and oscQualifiedIn again
    wire next_lockStatus = pllWrite ? 1'b0 : pllLockIn;
    wire next_oscQualified = pllWrite ? 1'b0 : oscQualifiedIn;
    wire lockChange = next_lockStatus != lockStatus;
    wire oscChange = next_oscQualified != oscQualified;
    wire [7:0] clearBits = flagsWrite ? (wrByte & MASK_FLAGS_W1C) : 8'h00;
    wire [7:0] setBits = {periodicTimerEvent, 2'b00, lockChange, 2'b00, oscChange, 1'b0};
    // Set wins over a simultaneous write-one clear
    wire [7:0] next_flags = ((flagsReg & ~clearBits) | setBits) & MASK_FLAGS_W1C;

    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            flagsReg <= 8'h00;
            lockStatus <= 1'b0;
            oscQualified <= 1'b0;
        end
        else
        begin
            flagsReg <= next_flags;
            lockStatus <= next_lockStatus;
            oscQualified <= next_oscQualified;
        end
    end

    // ************************************************************
    // Interrupt enables and requests
    // ************************************************************
    wire [7:0] next_irqEnable = irqEnWrite ? (wrByte & MASK_IRQ_EN) : irqEnable;

    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            irqEnable <= RST_IRQ_EN;
            periodicIrq <= 1'b0;
            lockIrq <= 1'b0;
            oscIrq <= 1'b0;
        end
        else
        begin
            irqEnable <= next_irqEnable;
            periodicIrq <= flagsReg[BIT_TIMER] && irqEnable[BIT_TIMER];
            lockIrq <= flagsReg[BIT_LOCK_CHG] && irqEnable[BIT_LOCK_CHG];
            oscIrq <= flagsReg[BIT_OSC_CHG] && irqEnable[BIT_OSC_CHG];
        end
    end

    // ************************************************************
    // Clock select
    // ************************************************************
    // Watchdog clock bit stays writable in normal mode until the one-time
    // configuration lands, or once more after qualification loss cleared it
    wire watchdogWritable = !watchdogOnceUsed || watchdogRearm;
    wire [7:0] normalMask = MASK_CLK_NORMAL | {7'h00, watchdogWritable};
    wire [7:0] writeMask = specialMode ? MASK_CLK_ALL : normalMask;
    wire [7:0] mergedSel = clkSelWrite ?
        ((clockSelect & ~writeMask) | (wrByte & writeMask)) : clockSelect;
    wire oscLost = !oscQualified;
    // PLL select may only drop while qualified; loss or full stop forces it
    wire next_system_clock_from_pll = (oscLost || fullStopEntry) ? 1'b1 : mergedSel[BIT_PLL_SEL];
    wire next_timerSel = oscLost ? 1'b0 : mergedSel[BIT_TIMER_CLK];
    wire next_watchdogSel = oscLost ? 1'b0 : mergedSel[BIT_WD_CLK];
    wire [7:0] next_clockSelect = {next_system_clock_from_pll, mergedSel[BIT_KEEP_OSC], 2'b00,
        mergedSel[BIT_TIMER_STOP], mergedSel[BIT_WD_STOP], next_timerSel, next_watchdogSel};
    // Re-arm is spent only by a normal-mode set that can really land
    wire watchdogSetByWrite = clkSelWrite && !specialMode && oscQualified &&
        writeMask[BIT_WD_CLK] && wrByte[BIT_WD_CLK];
    wire watchdogLostClear = clockSelect[BIT_WD_CLK] && oscLost;

    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            clockSelect <= RST_CLK_SEL;
            watchdogOnceUsed <= 1'b0;
            watchdogRearm <= 1'b0;
        end
        else
        begin
            clockSelect <= next_clockSelect;
            watchdogOnceUsed <= watchdogOnceUsed || watchdogConfigTaken;
            watchdogRearm <= watchdogLostClear || (watchdogRearm && !watchdogSetByWrite);
        end
    end

    // ************************************************************
    // Clock routing and stop behaviour
    // ************************************************************
    // Bus divider is fixed at two for both sources, so only the source and the unlocked divide-by-four flag leave here
    wire timerRunsInStop = next_clockSelect[BIT_KEEP_OSC] &&
        next_clockSelect[BIT_TIMER_STOP] && next_timerSel;
    wire watchdogRunsInStop = next_clockSelect[BIT_KEEP_OSC] &&
        next_clockSelect[BIT_WD_STOP] && next_watchdogSel;

    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            systemClockFromPll <= 1'b1;
            keepOscillatorInStop <= 1'b0;
            timerClockSelect <= 1'b0;
            watchdogClockSelect <= 1'b0;
            timerHalted <= 1'b0;
            watchdogHalted <= 1'b0;
            timerRestart <= 1'b0;
            watchdogRestart <= 1'b0;
            pllDivideByFour <= 1'b1;
        end
        else
        begin
            systemClockFromPll <= next_system_clock_from_pll;
            keepOscillatorInStop <= next_clockSelect[BIT_KEEP_OSC];
            timerClockSelect <= next_timerSel;
            watchdogClockSelect <= next_watchdogSel;
            // Halting freezes the counters; they are not reset
            timerHalted <= stopActive && !timerRunsInStop;
            watchdogHalted <= stopActive && !watchdogRunsInStop;
            timerRestart <= next_timerSel != clockSelect[BIT_TIMER_CLK];
            watchdogRestart <= next_watchdogSel != clockSelect[BIT_WD_CLK];
            pllDivideByFour <= !next_lockStatus;
        end
    end

    // ************************************************************
    // PLL modulation
    // ************************************************************
    wire [7:0] next_pllModulation = pllWrite ? (wrByte & MASK_PLL_MOD) : pllModulation;

    always_ff @(posedge clk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            pllModulation <= RST_PLL_MOD;
            pllStatusClear <= 1'b0;
            freqModAmplitude <= 2'b00;
        end
        else
        begin
            pllModulation <= next_pllModulation;
            pllStatusClear <= pllWrite;
            freqModAmplitude <= next_pllModulation[BIT_FM_HI:BIT_FM_LO];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstnSync);

    sequence timerPending;
        flagsReg[BIT_TIMER] && irqEnable[BIT_TIMER];
    endsequence
    sequence apbAccess;
        psel && !penable ##1 psel && penable;
    endsequence

    a_timer_irq_gate: assert property (timerPending |=> periodicIrq)
        else $error("periodic irq missing");
    a_timer_irq_mask: assert property (!irqEnable[BIT_TIMER] |=> !periodicIrq)
        else $error("periodic irq not masked");
    a_lock_irq_pair: assert property (lockIrq |-> $past(flagsReg[BIT_LOCK_CHG])
        && $past(irqEnable[BIT_LOCK_CHG])) else $error("lock irq without cause");
    a_osc_irq_pair: assert property (oscIrq == $past(flagsReg[BIT_OSC_CHG]
        && irqEnable[BIT_OSC_CHG])) else $error("osc irq mismatch");
    a_protect_blocks_sel: assert property (wrDone && hitClkSel && writeProtect
        && oscQualified && !fullStopEntry |=> $stable(clockSelect))
        else $error("protected clock select changed");
    a_loss_forces_sel: assert property (!oscQualified |=> systemClockFromPll
        && !timerClockSelect && !watchdogClockSelect) else $error("loss not forced");
    a_pll_write_gate: assert property (pllWriteTry && (writeProtect
        || !clockSelect[BIT_PLL_SEL]) |=> $stable(pllModulation))
        else $error("blocked pll write took effect");
    a_pll_clears_status: assert property (pllWrite |=> !lockStatus && !oscQualified
        ##1 !pllStatusClear[*1]) else $error("status not cleared");
    a_timer_restart: assert property ($changed(timerClockSelect) |-> timerRestart)
        else $error("timer restart missing");
    a_flag_set_wins: assert property (lockChange && flagsWrite |=> flagsReg[BIT_LOCK_CHG])
        else $error("lock flag lost");
    a_apb_ready: assert property (apbAccess |-> ##[0:1] pready)
        else $error("apb ready late");

    // ************************************************************
    // Assertions on masking, forcing, routing, halts, restarts, modulation and flags
    // ************************************************************
    a_timer_irq_flag: assert property (!flagsReg[BIT_TIMER] |=> !periodicIrq)
        else $error("periodic irq without flag");
    a_lock_irq_mask: assert property (!irqEnable[BIT_LOCK_CHG] |=> !lockIrq)
        else $error("lock irq not masked");
    a_osc_irq_mask: assert property (!irqEnable[BIT_OSC_CHG] |=> !oscIrq)
        else $error("osc irq not masked");
    a_special_write_all: assert property (clkSelWrite && specialMode
        && oscQualified && !fullStopEntry |=> clockSelect == $past(wrByte & MASK_CLK_ALL))
        else $error("special mode write lost");
    a_wd_sel_locked: assert property (clkSelWrite && !specialMode
        && watchdogOnceUsed && !watchdogRearm && oscQualified
        |=> clockSelect[BIT_WD_CLK] == $past(clockSelect[BIT_WD_CLK]))
        else $error("locked watchdog select changed");
    a_full_stop_sel: assert property (fullStopEntry |=> systemClockFromPll)
        else $error("full stop did not force pll");
    a_pll_drop_qual: assert property ($fell(systemClockFromPll) |-> $past(oscQualified))
        else $error("pll select dropped unqualified");
    a_timer_sel_qual: assert property ($rose(timerClockSelect) |-> $past(oscQualified))
        else $error("timer select set unqualified");
    a_wd_sel_qual: assert property ($rose(watchdogClockSelect) |-> $past(oscQualified))
        else $error("watchdog select set unqualified");

    a_timer_halt: assert property (stopActive && !timerRunsInStop |=> timerHalted)
        else $error("timer not halted");
    a_wd_halt: assert property (stopActive && !watchdogRunsInStop |=> watchdogHalted)
        else $error("watchdog not halted");
    a_wd_restart: assert property ($changed(watchdogClockSelect) |-> watchdogRestart)
        else $error("watchdog restart missing");
    a_wd_restart_only: assert property (watchdogRestart |-> $changed(watchdogClockSelect))
        else $error("spurious watchdog restart");

    a_mod_field: assert property (pllWrite
        |=> freqModAmplitude == $past(wrByte[BIT_FM_HI:BIT_FM_LO]))
        else $error("modulation amplitude wrong");
    a_mod_other_zero: assert property ((pllModulation & ~MASK_PLL_MOD) == 8'h00)
        else $error("modulation spare bits set");
    a_divide_unlocked: assert property (!next_lockStatus |=> pllDivideByFour)
        else $error("unlocked divide missing");

    a_lock_flag_set: assert property (lockChange |=> flagsReg[BIT_LOCK_CHG])
        else $error("lock flag not set");
    a_flag_w1c: assert property (flagsWrite && wrByte[BIT_TIMER]
        && !periodicTimerEvent |=> !flagsReg[BIT_TIMER]) else $error("timer flag not cleared");
    a_flag_sticky: assert property (flagsReg[BIT_TIMER]
        && !(flagsWrite && wrByte[BIT_TIMER]) |=> flagsReg[BIT_TIMER])
        else $error("timer flag dropped");

endmodule : clock_unit_select

// *** core/clock_unit_pkg.sv ***
// Purpose: Shared constants of the clock select and modulation control
// Assumes: APB with 32-bit data, register index times four is the byte address
// Notes: Narrow registers sit in the low byte, upper bits read zero
package clock_unit_pkg;
    localparam int ADDR_W = 10;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS = 8'h37;
    localparam logic [7:0] IDX_IRQ_EN = 8'h38;
    localparam logic [7:0] IDX_CLK_SEL = 8'h39;
    localparam logic [7:0] IDX_PLL_MOD = 8'h3A;
    // Flag and enable bit positions
    localparam int BIT_TIMER = 7;
    localparam int BIT_LOCK_CHG = 4;
    localparam int BIT_LOCK = 3;
    localparam int BIT_OSC_CHG = 1;
    localparam int BIT_OSC_UP = 0;
    // Clock select bit positions
    localparam int BIT_PLL_SEL = 7;
    localparam int BIT_KEEP_OSC = 6;
    localparam int BIT_TIMER_STOP = 3;
    localparam int BIT_WD_STOP = 2;
    localparam int BIT_TIMER_CLK = 1;
    localparam int BIT_WD_CLK = 0;
    // Modulation field
    localparam int BIT_FM_LO = 4;
    localparam int BIT_FM_HI = 5;
    // Masks of implemented bits
    localparam logic [7:0] MASK_FLAGS_W1C = 8'h92;
    localparam logic [7:0] MASK_IRQ_EN = 8'h92;
    localparam logic [7:0] MASK_CLK_NORMAL = 8'hCE;
    localparam logic [7:0] MASK_CLK_ALL = 8'hCF;
    localparam logic [7:0] MASK_PLL_MOD = 8'h30;
    // Reset values
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_CLK_SEL = 8'h80;
    localparam logic [7:0] RST_PLL_MOD = 8'h00;
    // Clock ratios
    localparam int BUS_DIVIDER = 2;
    localparam int UNLOCKED_DIVIDER = 4;
    localparam int FM_RATE_DIVIDER = 16;
endpackage : clock_unit_pkg

// *** test/clock_unit_select_and_fm_control_bench.sv ***
// Purpose: Self-checking bench for clock select, interrupt enables and modulation control
// Assumes: One wait state APB slave, status inputs driven synchronously to clk
// Notes: Transaction-level register model, compared after each group of operations has settled
`timescale 1ns/1ps
`define CHK(g, w) begin checksDone++; if ((g) !== (w)) begin errCount++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, w); end end

module clock_unit_select_and_fm_control_bench
    import clock_unit_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_FLG = {IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] A_IRQ = {IDX_IRQ_EN, 2'b00};
    localparam logic [ADDR_W-1:0] A_CLK = {IDX_CLK_SEL, 2'b00};
    localparam logic [ADDR_W-1:0] A_PLL = {IDX_PLL_MOD, 2'b00};
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic writeProtect, specialMode, watchdogConfigTaken, fullStopEntry, stopActive;
    logic periodicTimerEvent, pllLockIn, oscQualifiedIn, periodicIrq, lockIrq, oscIrq;
    logic systemClockFromPll, keepOscillatorInStop, timerClockSelect, watchdogClockSelect;
    logic timerHalted, watchdogHalted, timerRestart, watchdogRestart, pllDivideByFour;
    logic pllStatusClear;
    logic [1:0] freqModAmplitude;
    logic [7:0] irqTab [4] = '{8'h00, 8'h80, 8'h10, 8'h92};
    logic [ADDR_W-1:0] aTab [4] = '{A_FLG, A_IRQ, A_CLK, A_PLL};
    int mIrq = RST_IRQ_EN, mClk = RST_CLK_SEL, mPll = RST_PLL_MOD, mFlags = 0;
    int mLock = 0, mQual = 0, cfgTaken = 0, reArm = 0, seed = 32'hA34448BD;
    int expTr = 0, expWd = 0, expClr = 0, seenTr = 0, seenWd = 0, seenClr = 0;
    int errCount = 0, checksDone = 0;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    clock_unit_select dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .writeProtect(writeProtect), .specialMode(specialMode),
        .watchdogConfigTaken(watchdogConfigTaken), .fullStopEntry(fullStopEntry),
        .stopActive(stopActive), .periodicTimerEvent(periodicTimerEvent),
        .pllLockIn(pllLockIn), .oscQualifiedIn(oscQualifiedIn), .periodicIrq(periodicIrq),
        .lockIrq(lockIrq), .oscIrq(oscIrq), .systemClockFromPll(systemClockFromPll),
        .keepOscillatorInStop(keepOscillatorInStop), .timerClockSelect(timerClockSelect),
        .watchdogClockSelect(watchdogClockSelect), .timerHalted(timerHalted),
        .watchdogHalted(watchdogHalted), .timerRestart(timerRestart),
        .watchdogRestart(watchdogRestart), .pllDivideByFour(pllDivideByFour),
        .pllStatusClear(pllStatusClear), .freqModAmplitude(freqModAmplitude));

    // Restart and clear pulses last one cycle, so counting them catches missed or doubled ones
    always @(posedge clk)
    begin
        seenTr += (timerRestart === 1'b1);
        seenWd += (watchdogRestart === 1'b1);
        seenClr += (pllStatusClear === 1'b1);
    end

    // ************************************************************
    // Bus cycles and register model
    // ************************************************************
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($random(seed)), d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        errCount += (n >= 20);
    endtask : apb

    task automatic setClk(input int v);
        expTr += (v[1] != mClk[1]);
        expWd += (v[0] != mClk[0]);
        mClk = v;
    endtask : setClk

    task automatic statusTo(input int lv, input int qv);
        if (lv != mLock) mFlags |= 8'h10;
        if (qv != mQual) mFlags |= 8'h02;
        if (mQual && !qv)
        begin
            if (mClk[0]) reArm = 1;
            setClk((mClk | 8'h80) & 8'hFC);
        end
        mLock = lv;
        mQual = qv;
    endtask : statusTo

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int m;
        apb(1'b1, a, d);
        m = specialMode ? MASK_CLK_ALL : (MASK_CLK_NORMAL | (!cfgTaken || reArm));
        if (a == A_FLG) mFlags &= ~(d & MASK_FLAGS_W1C);
        if (a == A_IRQ) mIrq = d & MASK_IRQ_EN;
        if (a == A_CLK && !writeProtect)
        begin
            if (!specialMode && reArm && d[0] && mQual) reArm = 0;
            m = (mClk & ~m) | (d & m);
            setClk(mQual ? m : ((m | 8'h80) & 8'hFC));
        end
        if (a == A_PLL && !writeProtect && mClk[7])
        begin
            mPll = d & MASK_PLL_MOD;
            expClr++;
            statusTo(0, 0);
            statusTo(pllLockIn, oscQualifiedIn);
        end
        repeat (4) @(posedge clk);
    endtask : wr

    task automatic setStatus(input logic lv, input logic qv);
        @(posedge clk);
        pllLockIn <= lv;
        oscQualifiedIn <= qv;
        repeat (4) @(posedge clk);
        statusTo(lv, qv);
    endtask : setStatus

    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        {fullStopEntry, watchdogConfigTaken, periodicTimerEvent} <= m;
        @(posedge clk);
        {fullStopEntry, watchdogConfigTaken, periodicTimerEvent} <= 3'h0;
        repeat (3) @(posedge clk);
        if (m[0]) mFlags |= 8'h80;
        if (m[1]) cfgTaken = 1;
        if (m[2]) setClk(mClk | 8'h80);
    endtask : pulse

    task automatic drive(input logic [2:0] m);
        @(posedge clk);
        {writeProtect, specialMode, stopActive} <= m;
    endtask : drive

    task automatic rdc(input logic [ADDR_W-1:0] a, input int x);
        apb(1'b0, a, 8'h00);
        `CHK(rd, 32'(x))
        `CHK(er, 1'b0)
    endtask : rdc

    task automatic checkAll();
        rdc(A_FLG, mFlags | (mLock << 3) | mQual);
        rdc(A_IRQ, mIrq);
        rdc(A_CLK, mClk);
        rdc(A_PLL, mPll);
        `CHK(periodicIrq, 1'(mFlags[7] & mIrq[7]))
        `CHK(lockIrq, 1'(mFlags[4] & mIrq[4]))
        `CHK(oscIrq, 1'(mFlags[1] & mIrq[1]))
        `CHK(systemClockFromPll, 1'(mClk[7]))
        `CHK(keepOscillatorInStop, 1'(mClk[6]))
        `CHK({timerClockSelect, watchdogClockSelect}, 2'(mClk))
        `CHK(timerHalted, stopActive & !(mClk[6] & mClk[3] & mClk[1]))
        `CHK(watchdogHalted, stopActive & !(mClk[6] & mClk[2] & mClk[0]))
        `CHK(freqModAmplitude, 2'(mPll >> 4))
        `CHK(pllDivideByFour, 1'(!mLock))
        `CHK(seenTr, expTr)
        `CHK(seenWd, expWd)
        `CHK(seenClr, expClr)
    endtask : checkAll

    task automatic results();
        $display("Comparisons: %0d, mismatches: %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        {rstn, psel, penable, pwrite, writeProtect, specialMode, stopActive} = 7'h00;
        {watchdogConfigTaken, fullStopEntry, periodicTimerEvent} = 3'h0;
        {pllLockIn, oscQualifiedIn, paddr, pwdata} = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        checkAll();
        apb(1'b0, 10'h3FC, 8'h00);
        `CHK({er, rd}, 33'h100000000)
        setStatus(1'b1, 1'b1);
        checkAll();
        for (int i = 0; i < 4; i++)
        begin
            wr(A_IRQ, irqTab[i]);
            pulse(3'b001);
            setStatus(!pllLockIn, 1'b1);
            checkAll();
            wr(A_FLG, 8'($random(seed)));
            checkAll();
        end
        drive(3'b100);
        wr(A_CLK, 8'h4F);
        checkAll();
        // Oscillator qualified long before stop is entered
        drive(3'b001);
        wr(A_CLK, 8'h4F);
        checkAll();
        pulse(3'b010);
        wr(A_CLK, 8'h4E);
        checkAll();
        setStatus(pllLockIn, 1'b0);
        wr(A_CLK, 8'h4F);
        checkAll();
        setStatus(pllLockIn, 1'b1);
        wr(A_CLK, 8'h4F);
        checkAll();
        wr(A_CLK, 8'h4E);
        drive(3'b010);
        wr(A_CLK, 8'h0C);
        pulse(3'b100);
        checkAll();
        drive(3'b000);
        // No adaptive filter in this bench, so modulation may be enabled
        for (int f = 0; f < 4; f++)
        begin
            wr(A_PLL, 8'(8'hCF | (f << 4)));
            checkAll();
        end
        // Random mix: protection, mode, stop, status churn and writes to every register
        for (int k = 0; k < 60; k++)
        begin
            drive({1'(($random(seed) & 3) == 0), 2'($random(seed))});
            if (($random(seed) & 3) == 0) setStatus(1'($random(seed)), 1'($random(seed) & 1));
            wr(aTab[2'($random(seed))], 8'($random(seed)));
            checkAll();
        end
        results();
    end

    // Whole run needs a few thousand cycles; this leaves a wide margin
    initial
    begin
        #(50 * 60000);
        errCount++;
        results();
    end
endmodule : clock_unit_select_and_fm_control_bench
